// *** rtl/cmp_ctrl_params.svh ***
// Register offsets, field positions, reset values and timing for the
// comparator control logic. Included by the package file only.
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h08
`define OFS_IEN 8'h0C
`define OFS_IF 8'h10
`define OFS_IFS 8'h14
`define OFS_IFC 8'h18

// Control field positions
`define CTRL_EN_BIT 0
`define CTRL_MUXEN_BIT 1
`define CTRL_IDLE_BIT 2
`define CTRL_GPIOINV_BIT 3
`define CTRL_HYST_LSB 4
`define CTRL_SETTLE_LSB 8
`define CTRL_RISE_BIT 16
`define CTRL_FALL_BIT 17
`define CTRL_BIAS_LSB 24
`define CTRL_HALVE_BIT 30
`define CTRL_BOOST_BIT 31

// Status and flag positions
`define STAT_ACTIVE_BIT 0
`define STAT_RESULT_BIT 1
`define FLAG_EDGE_BIT 0
`define FLAG_WARM_BIT 1

// Reset values
`define RST_BIAS_LEVEL 4'h7
`define RST_BIAS_HALVE 1'b1

// Shortest settle interval, cycles
`define SETTLE_BASE_CYCLES 4

`endif

// *** rtl/cmp_ctrl_pkg.sv ***
// Types shared by the comparator control logic.
// Assumes the params header sits on the include path.
`include "cmp_ctrl_params.svh"

package cmp_ctrl_pkg;

  typedef struct packed {
    logic bias_boost;
    logic bias_halve;
    logic [3:0] bias_level_code;
    logic falling_edge_sense;
    logic rising_edge_sense;
    logic [2:0] settle_interval_select;
    logic [2:0] hysteresis_level_select;
    logic gpio_invert;
    logic idle_output_value;
    logic mux_force;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic enable;
    logic mux_force;
    logic [3:0] bias_level_code;
    logic bias_boost;
    logic bias_halve;
    logic [2:0] hysteresis_level_select;
  } analog_cfg_t;

  typedef enum logic [1:0] {
    WARM_IDLE = 2'b00,
    WARM_COUNT = 2'b01,
    WARM_ACTIVE = 2'b10
  } warm_state_t;

endpackage

// *** rtl/cmp_result_sync.sv ***
// Three-stage synchroniser for the raw comparator result.
// Assumes the input is asynchronous to i_ref_clk.
module cmp_result_sync (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Raw and clean result
  input wire logic i_raw,
  output logic o_clean
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic clean_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clean_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      clean_q <= s3_q;
    end
  end

  assign o_clean = clean_q;

endmodule

// *** rtl/cmp_settle_timer.sv ***
// Settle interval timer for the comparator.
// Assumes i_enable comes from a register on the same clock.
module cmp_settle_timer import cmp_ctrl_pkg::*; #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic [2:0] i_select,
  // Status
  output logic o_done,
  output logic o_active
);

  warm_state_t state_q;
  warm_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;

  // 4 << select gives 4..512 cycles
  assign target = CNT_W'(`SETTLE_BASE_CYCLES) << i_select;
  assign o_done = (state_q == WARM_COUNT) && i_enable && (cnt_q == target - 1'b1);
  assign o_active = (state_q == WARM_ACTIVE) && i_enable;

  always_comb begin
    state_d = state_q;
    case (state_q)
      WARM_IDLE: if (i_enable) state_d = WARM_COUNT;
      WARM_COUNT: if (!i_enable) state_d = WARM_IDLE; else if (o_done) state_d = WARM_ACTIVE;
      WARM_ACTIVE: if (!i_enable) state_d = WARM_IDLE;
      default: state_d = WARM_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= WARM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (state_d == WARM_COUNT) begin
      cnt_q <= (state_q == WARM_COUNT) ? cnt_q + 1'b1 : CNT_W'(1);
    end else begin
      cnt_q <= '0;
    end
  end

endmodule

// *** rtl/comparator_control_logic.sv ***
// Digital control around an analog voltage comparator.
// Assumes a register master on i_ref_clk and a raw result from the core.
//
// Summary of operation
// R1 - Output high when positive input exceeds negative, else low.
// R2 - Current result readable as a status bit.
// R3 - Software changes only input selection while enabled.
// R4 - After enable, count the selected settle interval before use.
// R5 - Software picks a settle interval of at least 10 us.
// R6 - Active indicator set once enabled and settled.
// R7 - While inactive, output shows the idle output value.
// R8 - At settle end, edge interrupt if result differs from idle value.
// R9 - Software waits for settling before the two deepest sleep levels.
// R10 - Hold four-bit bias level code, boost bit and halving bit.
// R11 - Software uses highest hysteresis whenever bias boost is set.
// R12 - Hold three-bit hysteresis level select, eight levels.
// R13 - Settle select 0..7 means 4..512 clock cycles.
// R14 - Edge flag on rising or falling edge per sense bits.
// R15 - Settle-done flag set, interrupt if enabled.
// R16 - Raw result synchronised before any use.
// R17 - Disabling drops active, restores idle value, restarts settling.
module comparator_control_logic import cmp_ctrl_pkg::*; #(
  parameter int SETTLE_CNT_W = 10
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Analog core
  input wire logic i_cmp_raw,
  output analog_cfg_t o_analog_cfg,
  // Result outputs
  output logic o_cmp_out,
  output logic o_gpio_out,
  // Interrupt
  output logic o_irq
);

  ctrl_t ctrl_q;
  logic [1:0] ien_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic out_q;
  logic out_d;
  logic gpio_q;
  analog_cfg_t cfg_q;
  logic res_sync;
  logic warm_done;
  logic active_w;
  logic rise_evt;
  logic fall_evt;
  logic edge_evt;
  logic wr_ctrl;
  logic wr_ien;
  logic wr_if;
  logic wr_ifs;
  logic wr_ifc;

  // Write decode
  assign wr_ctrl = i_wr && (i_addr == `OFS_CTRL);
  assign wr_ien = i_wr && (i_addr == `OFS_IEN);
  assign wr_if = i_wr && (i_addr == `OFS_IF);
  assign wr_ifs = i_wr && (i_addr == `OFS_IFS);
  assign wr_ifc = i_wr && (i_addr == `OFS_IFC);

  // Raw result into the clock domain
  cmp_result_sync u_sync ( // [R16]
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_raw(i_cmp_raw),
    .o_clean(res_sync)
  );

  // Settle timer, restarted whenever enable drops
  cmp_settle_timer #(
    .CNT_W(SETTLE_CNT_W)
  ) u_settle ( // [R4] [R13] [R17]
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(ctrl_q.enable),
    .i_select(ctrl_q.settle_interval_select),
    .o_done(warm_done),
    .o_active(active_w)
  );

  // Control register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= '0;
      ctrl_q.bias_level_code <= `RST_BIAS_LEVEL;
      ctrl_q.bias_halve <= `RST_BIAS_HALVE;
    end else if (wr_ctrl) begin
      ctrl_q.enable <= i_wdata[`CTRL_EN_BIT];
      ctrl_q.mux_force <= i_wdata[`CTRL_MUXEN_BIT];
      ctrl_q.idle_output_value <= i_wdata[`CTRL_IDLE_BIT];
      ctrl_q.gpio_invert <= i_wdata[`CTRL_GPIOINV_BIT];
      ctrl_q.hysteresis_level_select <= i_wdata[`CTRL_HYST_LSB +: 3]; // [R12]
      ctrl_q.settle_interval_select <= i_wdata[`CTRL_SETTLE_LSB +: 3]; // [R13]
      ctrl_q.rising_edge_sense <= i_wdata[`CTRL_RISE_BIT];
      ctrl_q.falling_edge_sense <= i_wdata[`CTRL_FALL_BIT];
      ctrl_q.bias_level_code <= i_wdata[`CTRL_BIAS_LSB +: 4]; // [R10]
      ctrl_q.bias_halve <= i_wdata[`CTRL_HALVE_BIT]; // [R10]
      ctrl_q.bias_boost <= i_wdata[`CTRL_BOOST_BIT]; // [R10]
    end
  end

  // Interrupt enable register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ien_q <= 2'h0;
    end else if (wr_ien) begin
      ien_q <= i_wdata[1:0];
    end
  end

  // Configuration driven to the analog core
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= '0;
      cfg_q.bias_level_code <= `RST_BIAS_LEVEL;
      cfg_q.bias_halve <= `RST_BIAS_HALVE;
    end else begin
      cfg_q.enable <= ctrl_q.enable;
      cfg_q.mux_force <= ctrl_q.mux_force;
      cfg_q.bias_level_code <= ctrl_q.bias_level_code; // [R10]
      cfg_q.bias_boost <= ctrl_q.bias_boost; // [R10]
      cfg_q.bias_halve <= ctrl_q.bias_halve; // [R10]
      cfg_q.hysteresis_level_select <= ctrl_q.hysteresis_level_select; // [R12]
    end
  end

  assign o_analog_cfg = cfg_q;

  // Output select: result when active, idle value otherwise
  assign out_d = active_w ? res_sync : ctrl_q.idle_output_value; // [R1] [R7] [R17]

  // Edges seen on the selected output while active; the settle end
  // counts as an edge when the result differs from the idle value
  assign rise_evt = active_w && out_d && !out_q; // [R8] [R14]
  assign fall_evt = active_w && !out_d && out_q; // [R8] [R14]
  assign edge_evt = (rise_evt && ctrl_q.rising_edge_sense) ||
                    (fall_evt && ctrl_q.falling_edge_sense); // [R14]

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_q <= 1'b0;
    end else begin
      gpio_q <= out_d ^ ctrl_q.gpio_invert;
    end
  end

  assign o_cmp_out = out_q;
  assign o_gpio_out = gpio_q;

  // Sticky flags; a set in the clearing cycle wins
  always_comb begin
    flag_set = 2'h0;
    flag_set[`FLAG_EDGE_BIT] = edge_evt; // [R8] [R14]
    flag_set[`FLAG_WARM_BIT] = warm_done; // [R15]
    if (wr_ifs) begin
      flag_set = flag_set | i_wdata[1:0];
    end
    flag_clr = 2'h0;
    if (wr_if || wr_ifc) begin
      flag_clr = i_wdata[1:0];
    end
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= 2'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_irq = |(flags_q & ien_q); // [R15]

  // Read mux, data one cycle after the strobe
  always_comb begin
    rdata_d = 32'h0;
    case (i_addr)
      `OFS_CTRL: begin
        rdata_d[`CTRL_EN_BIT] = ctrl_q.enable;
        rdata_d[`CTRL_MUXEN_BIT] = ctrl_q.mux_force;
        rdata_d[`CTRL_IDLE_BIT] = ctrl_q.idle_output_value;
        rdata_d[`CTRL_GPIOINV_BIT] = ctrl_q.gpio_invert;
        rdata_d[`CTRL_HYST_LSB +: 3] = ctrl_q.hysteresis_level_select;
        rdata_d[`CTRL_SETTLE_LSB +: 3] = ctrl_q.settle_interval_select;
        rdata_d[`CTRL_RISE_BIT] = ctrl_q.rising_edge_sense;
        rdata_d[`CTRL_FALL_BIT] = ctrl_q.falling_edge_sense;
        rdata_d[`CTRL_BIAS_LSB +: 4] = ctrl_q.bias_level_code;
        rdata_d[`CTRL_HALVE_BIT] = ctrl_q.bias_halve;
        rdata_d[`CTRL_BOOST_BIT] = ctrl_q.bias_boost;
      end
      `OFS_STATUS: begin
        rdata_d[`STAT_ACTIVE_BIT] = active_w; // [R6]
        rdata_d[`STAT_RESULT_BIT] = out_d; // [R2]
      end
      `OFS_IEN: rdata_d[1:0] = ien_q;
      `OFS_IF: rdata_d[1:0] = flags_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign o_rdata = rdata_q;

  // Checks
  sequence s_en_rise;
    $rose(ctrl_q.enable);
  endsequence

  sequence s_read_status;
    i_rd && (i_addr == `OFS_STATUS);
  endsequence

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  AST_SETTLE_MIN: assert property ( // [R4]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_en_rise |-> !active_w [*4]
  ) else $error("Active before shortest settle interval");

  AST_SETTLE_FAST: assert property ( // [R13]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_en_rise ##0 (ctrl_q.settle_interval_select == 3'h0 && !wr_ctrl))
      ##1 (ctrl_q.enable && !wr_ctrl) [*3] |-> ##1 active_w
  ) else $error("Four-cycle settle interval not honoured");

  AST_DISABLE_DROP: assert property ( // [R17]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(ctrl_q.enable) |-> !active_w ##1 (o_cmp_out == $past(ctrl_q.idle_output_value))
  ) else $error("Disable did not drop active or restore idle value");

  AST_IDLE_OUT: assert property ( // [R7]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !active_w |=> o_cmp_out == $past(ctrl_q.idle_output_value)
  ) else $error("Inactive output not the idle value");

  AST_RESULT_OUT: assert property ( // [R1]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    active_w |=> o_cmp_out == $past(res_sync)
  ) else $error("Active output does not follow result");

  AST_STATUS_READ: assert property ( // [R2]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_read_status |=> o_rdata[`STAT_ACTIVE_BIT] == $past(active_w)
      && o_rdata[`STAT_RESULT_BIT] == $past(out_d)
  ) else $error("Status read mismatch");

  AST_ACTIVE_AFTER_DONE: assert property ( // [R6]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    warm_done && !wr_ctrl |=> active_w
  ) else $error("Active not set after settling");

  sequence s_settle_end;
    warm_done && !wr_ctrl;
  endsequence

  sequence s_result_differs;
    active_w && (res_sync != ctrl_q.idle_output_value)
      && (res_sync ? ctrl_q.rising_edge_sense : ctrl_q.falling_edge_sense);
  endsequence

  AST_SETTLE_EDGE: assert property ( // [R8]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_settle_end ##1 s_result_differs |=> flags_q[`FLAG_EDGE_BIT]
  ) else $error("No edge flag at settle end");

  AST_RISE_FLAG: assert property ( // [R14]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    rise_evt && ctrl_q.rising_edge_sense |=> flags_q[`FLAG_EDGE_BIT]
  ) else $error("Rising edge not flagged");

  AST_NO_FALL_FLAG: assert property ( // [R14]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !flags_q[`FLAG_EDGE_BIT] && fall_evt && !ctrl_q.falling_edge_sense
      && !rise_evt && !wr_ifs |=> !flags_q[`FLAG_EDGE_BIT]
  ) else $error("Falling edge flagged while sense off");

  AST_WARM_IRQ: assert property ( // [R15]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    warm_done && ien_q[`FLAG_WARM_BIT] && !wr_ien |=> o_irq
  ) else $error("Settle-done interrupt missing");

  AST_BIAS_CFG: assert property ( // [R10]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_ctrl_write |=> ##1 o_analog_cfg.bias_level_code == $past(i_wdata[27:24], 2)
      && o_analog_cfg.bias_halve == $past(i_wdata[30], 2)
  ) else $error("Bias code not passed to core");

  AST_HYST_CFG: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_ctrl_write |=> ##1 o_analog_cfg.hysteresis_level_select == $past(i_wdata[6:4], 2)
  ) else $error("Hysteresis select not passed to core");

  AST_SYNC_LAG: assert property ( // [R16]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $changed(res_sync) |-> $past(i_cmp_raw, 3) == res_sync
  ) else $error("Result changed without synchroniser delay");

  AST_WARM_FLAG: assert property ( // [R15]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    warm_done |=> flags_q[`FLAG_WARM_BIT]
  ) else $error("Settle-done flag not set");

  AST_NO_EDGE_IDLE: assert property ( // [R17]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !active_w && !flags_q[`FLAG_EDGE_BIT] && !wr_ifs |=> !flags_q[`FLAG_EDGE_BIT]
  ) else $error("Edge flagged while inactive");

  AST_CFG_DISABLE: assert property ( // [R17]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(ctrl_q.enable) |=> !o_analog_cfg.enable
  ) else $error("Core still enabled after disable");

endmodule

// *** tb/cmp_core_model.sv ***
// Behavioural analog comparator core facing the control logic.
// Assumes millivolt levels from the bench and the design's clock.
module cmp_core_model import cmp_ctrl_pkg::*; #(
  parameter int SETTLE_CYC = 0,
  parameter int HYST_STEP_MV = 10
) (
  // Clock
  input wire logic i_ref_clk,
  // Analog side
  input wire analog_cfg_t i_cfg,
  input wire logic [11:0] i_pos_mv,
  input wire logic [11:0] i_neg_mv,
  // Result
  output logic o_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt = 0;
  int thr;
  logic res_q = 1'b0;
  always @(posedge i_ref_clk) begin
    thr = HYST_STEP_MV * int'(i_cfg.hysteresis_level_select);
    if (!i_cfg.enable || on_cnt < SETTLE_CYC) begin
      res_q <= ~res_q;
    end else if (int'(i_pos_mv) > int'(i_neg_mv) + thr) begin
      res_q <= 1'b1;
    end else if (int'(i_pos_mv) < int'(i_neg_mv) - thr) begin
      res_q <= 1'b0;
    end
    on_cnt <= i_cfg.enable ? on_cnt + 1 : 0;
  end
  assign o_raw = res_q;
endmodule

// *** tb/tb_comparator_control_logic.sv ***
// Self-checking bench for the comparator control logic.
// Assumes the core model drives the raw result from bench levels.
module tb_comparator_control_logic;
  import cmp_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic raw;
  analog_cfg_t cfg;
  logic cmp_out;
  logic gpio_out;
  logic irq;
  logic [11:0] pos_mv;
  logic [11:0] neg_mv;
  logic [11:0] base;
  logic [31:0] d;
  logic [3:0] bi;
  logic [2:0] hy;
  logic idle, inv, ri, fa, res, bo, ha, edg, mx;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] ra[5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h04};
  logic [31:0] rv[5] = '{32'h47000000, 32'h0, 32'h0, 32'h0, 32'h0};

  always #25 ref_clk = ~ref_clk;

  comparator_control_logic #(.SETTLE_CNT_W(10)) comparator_control_logic_i (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_cmp_raw(raw), .o_analog_cfg(cfg), .o_cmp_out(cmp_out),
    .o_gpio_out(gpio_out), .o_irq(irq));

  cmp_core_model #(.SETTLE_CYC(0)) cmp_core_model_i (
    .i_ref_clk(ref_clk), .i_cfg(cfg), .i_pos_mv(pos_mv), .i_neg_mv(neg_mv), .o_raw(raw));

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask

  // Control word from field values
  function automatic logic [31:0] mk(input logic en, input logic [2:0] st);
    return {bo, ha, 2'h0, bi, 6'h0, fa, ri, 5'h0, st, 1'h0, hy, inv, idle, mx, en};
  endfunction

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    pos_mv = 12'h0;
    neg_mv = 12'h0;
    void'($urandom(32'hF4C1));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk(32'(cfg), {21'h0, 2'h0, 4'h7, 2'h1, 3'h0});
    for (int k = 0; k < 5; k++) rd_chk(ra[k], rv[k]);
    wr_reg(8'h08, 32'hFFFFFFFF);
    wr_reg(8'h04, 32'hFFFFFFFF);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h04, 32'h0);
    // Bias and hysteresis fields, boost only with highest hysteresis
    for (int h = 0; h < 8; h++) begin
      hy = h[2:0];
      bi = 4'($urandom);
      ha = 1'($urandom);
      bo = (h == 7) ? 1'($urandom) : 1'b0;
      idle = 1'b0; inv = 1'b0; ri = 1'b0; fa = 1'b0;
      mx = 1'($urandom);
      wr_reg(8'h00, mk(1'b0, 3'h0));
      @(posedge ref_clk);
      #1 chk(32'(cfg), {21'h0, 1'b0, mx, bi, bo, ha, hy});
      rd_chk(8'h00, mk(1'b0, 3'h0));
    end
    bi = 4'h7; ha = 1'b1; bo = 1'b0; hy = 3'h0;
    mx = 1'b0;
    // Warm-up over every settle code, then live edges and disable
    for (int s = 0; s < 8; s++) begin
      idle = 1'($urandom); inv = 1'($urandom); ri = 1'($urandom); fa = 1'($urandom);
      res = 1'($urandom);
      base = 12'(1000 + $urandom_range(999));
      pos_mv <= res ? base + 12'h190 : base;
      neg_mv <= res ? base : base + 12'h190;
      wr_reg(8'h18, 32'h3);
      wr_reg(8'h0C, 32'h2);
      wr_reg(8'h00, mk(1'b1, s[2:0]));
      repeat ((4 << s) - 1) @(posedge ref_clk);
      #1 chk({30'h0, irq, cmp_out}, {30'h0, 1'b0, idle});
      chk({31'h0, gpio_out}, {31'h0, idle ^ inv});
      @(posedge ref_clk);
      #1 chk({31'h0, irq}, 32'h1);
      repeat (6) @(posedge ref_clk);
      rd_chk(8'h08, {30'h0, res, 1'b1});
      chk({30'h0, gpio_out, cmp_out}, {30'h0, res ^ inv, res});
      edg = (res != idle) && (res ? ri : fa);
      rd_reg(8'h10, d);
      chk(d & {31'h1, s != 0}, {30'h0, 1'b1, edg && s != 0});
      wr_reg(8'h18, 32'h3);
      pos_mv <= neg_mv;
      neg_mv <= pos_mv;
      res = ~res;
      repeat (7) @(posedge ref_clk);
      rd_chk(8'h10, {31'h0, res ? ri : fa});
      chk({31'h0, cmp_out}, {31'h0, res});
      wr_reg(8'h00, mk(1'b0, s[2:0]));
      @(posedge ref_clk);
      #1 chk({31'h0, cmp_out}, {31'h0, idle});
      rd_chk(8'h08, {30'h0, idle, 1'b0});
      rd_chk(8'h10, {31'h0, res ? ri : fa});
    end
    // Flag set, mask and the two clear paths
    wr_reg(8'h0C, 32'h0);
    wr_reg(8'h14, 32'h3);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(8'h10, 32'h3);
    wr_reg(8'h0C, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    wr_reg(8'h10, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(8'h10, 32'h2);
    wr_reg(8'h18, 32'h2);
    rd_chk(8'h10, 32'h0);
    stop_test();
  end
endmodule
